// ---- lf_coil_consts.vh ----
// constants for the lf coil fault and current control block
`ifndef LF_COIL_CONSTS_VH
`define LF_COIL_CONSTS_VH

// ===========================================================
// channel and current step layout
`define NUM_COILS 6
`define NUM_STEPS 20
`define STEP_W 5
`define STEP_RESET 5'h00
// ===========================================================
// boost switching clock: 8 MHz oscillator / 64 = 125 kHz
`define OSC_HZ 8000000
`define BOOST_HZ 125000
`define BOOST_DIV (`OSC_HZ / `BOOST_HZ)
`define BOOST_DIV_W 6
// ===========================================================
// fault cause register bit positions
`define FC_SHORT_VS 0
`define FC_SHORT_GND 1
`define FC_OPEN_LOAD 2
`define FC_OVER_TEMP 3
`define FC_W 4
`define FAULT_RESET 4'h0
// ===========================================================
// operating states
`define ST_IDLE 2'h0
`define ST_OPER 2'h1
`define ST_SHUT 2'h2
`define ST_DIAG 2'h3

`endif

// ---- lf_boost_divider.v ----
// boost switching clock divider derived from the oscillator clock
`timescale 1ns/10ps
`include "lf_coil_consts.vh"
module lf_boost_divider #(
    parameter DIV = `BOOST_DIV,
    parameter W = `BOOST_DIV_W
) (
    input wire i_clk, // oscillator-derived clock
    input wire i_rst_n, // async reset, active low
    input wire i_run, // divider runs only while set
    output reg o_tick, // one pulse per switching period
    output reg o_phase // square wave, half period high
);
    // ===========================================================
    // counter
    reg [W-1:0] cnt; // position within a switching period
    // cut to the counter width on purpose: a divider of 2**W wraps to all ones
    localparam [W-1:0] LAST = DIV[W-1:0] - 1'b1;
    localparam [W-1:0] HALF = DIV[W:1];

    // stopping resets phase so each transmission starts a fresh period
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt <= {W{1'b0}};
            o_tick <= 1'b0;
            o_phase <= 1'b0;
        end
        else if (!i_run)
        begin
            cnt <= {W{1'b0}};
            o_tick <= 1'b0;
            o_phase <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == LAST) ? {W{1'b0}} : cnt + 1'b1;
            o_tick <= (cnt == LAST);
            o_phase <= (cnt < HALF);
        end
    end
endmodule

// ---- lf_coil_ctrl.v ----
// fault protection, current step, boost gating and peak sampling control
`timescale 1ns/10ps
`include "lf_coil_consts.vh"

// Functional notes
// RQ1: line short sets all drivers high impedance
// RQ2: shutdown disconnects shunt from return lines
// RQ3: shutdown latches fault cause for readback
// RQ4: each shutdown raises interrupt request
// RQ5: open load, overtemperature also shut down
// RQ6: fault monitoring runs continuously; the code suspends it in diagnosis mode
// RQ7: reset-fault command restores transmissions
// RQ8: boost enabled only during transmission
// RQ9: boost current limit, overvoltage stops converter
// RQ10: boost clock is oscillator over sixty-four
// RQ11: twenty current steps set regulation reference
// RQ12: controller: lowest four steps low coils
// RQ13: controller: middle ten steps either group
// RQ14: controller: upper six steps high coils
// RQ15: any valid step accepted for any group
// RQ16: idle holds integrator at battery level
// RQ17: zero crossings time positive peak sampling
// RQ18: line tests activatable and readable
// RQ19: shutdown ignores transmissions, interface still idle-like
// RQ20: cause and interrupt latched until reset-fault
module lf_coil_ctrl #(
    parameter NC = `NUM_COILS,
    parameter SW = `STEP_W
) (
    input wire i_clk, // oscillator clock, 250 MHz model
    input wire i_rst_n, // async reset, active low
    input wire [2:0] i_coil_sel, // selected coil index 0..5
    input wire i_tx_start, // transmission command pulse
    input wire i_tx_stop, // end of transmission pulse
    input wire i_step_wr, // current step write strobe
    input wire [SW-1:0] i_step_data, // current step code 0..19
    input wire i_diag_enter, // enter diagnosis mode pulse
    input wire i_diag_exit, // leave diagnosis mode pulse
    input wire [1:0] i_diag_sw, // test switch bits p,n for selected coil
    input wire i_diag_wr, // latch test switch bits strobe
    input wire i_fault_clear, // reset-fault command pulse
    input wire [NC-1:0] i_pos_short_vs, // coil_positive_line short to supply, pin
    input wire [NC-1:0] i_pos_short_gnd, // coil_positive_line short to ground, pin
    input wire [NC-1:0] i_ret_short_vs, // coil_return_line short to supply, pin
    input wire [NC-1:0] i_ret_short_gnd, // coil_return_line short to ground, pin
    input wire i_open_load, // open load comparator, pin
    input wire i_over_temp, // junction overtemperature, pin
    input wire i_boost_ilim, // low-side switch peak current limit, pin
    input wire i_boost_ovp, // driver_supply_rail over limit, pin
    input wire i_shunt_sense_input, // shunt sense above zero comparator, pin
    input wire [2*NC-1:0] i_line_level, // test comparators p,n per coil, pin
    output reg [NC-1:0] o_drv_en, // driver enable per coil, low is high impedance
    output reg o_shunt_conn, // shunt connected to return lines
    output reg [`FC_W-1:0] o_fault_cause, // latched fault cause
    output reg o_irq, // interrupt request, active high level
    output reg [SW-1:0] o_step_ref, // regulation reference step
    output reg o_boost_en, // boost converter enable
    output reg o_boost_gate, // boost low-side switch gate
    output reg o_integ_hold_batt, // integrator_cap_node held at battery level
    output reg o_peak_sample, // sample pulse at positive current peak
    output reg o_diag_mode, // diagnosis mode active
    output reg [2*NC-1:0] o_diag_sw, // latched test switch bits p,n per coil
    output reg [1:0] o_line_status, // selected coil line levels p,n
    output reg [1:0] o_state // operating state
);
    // ===========================================================
    // input synchronisers: three stages, change counts when 2nd and 3rd agree
    localparam SYN_W = 4 * NC + 5 + 2 * NC;
    wire [SYN_W-1:0] raw_in; // all asynchronous inputs
    reg [SYN_W-1:0] sync1; // first stage, read only by sync2
    reg [SYN_W-1:0] sync2; // second stage
    reg [SYN_W-1:0] sync3; // third stage
    reg [SYN_W-1:0] filt; // accepted value
    assign raw_in = {i_line_level, i_shunt_sense_input, i_boost_ovp, i_boost_ilim,
                     i_over_temp, i_open_load, i_ret_short_gnd, i_ret_short_vs,
                     i_pos_short_gnd, i_pos_short_vs};

    genvar g;
    generate
        for (g = 0; g < SYN_W; g = g + 1)
        begin : g_sync
            // each bit only updates once two later stages agree, rejects one-cycle glitches
            always @(posedge i_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                    sync3[g] <= 1'b0;
                    filt[g] <= 1'b0;
                end
                else
                begin
                    sync1[g] <= raw_in[g];
                    sync2[g] <= sync1[g];
                    sync3[g] <= sync2[g];
                    if (sync2[g] == sync3[g])
                        filt[g] <= sync3[g];
                end
            end
        end
    endgenerate

    // ===========================================================
    // decoded fault sources
    wire [NC-1:0] s_pos_vs = filt[NC-1:0]; // positive line to supply
    wire [NC-1:0] s_pos_gnd = filt[2*NC-1:NC]; // positive line to ground
    wire [NC-1:0] s_ret_vs = filt[3*NC-1:2*NC]; // return line to supply
    wire [NC-1:0] s_ret_gnd = filt[4*NC-1:3*NC]; // return line to ground
    wire s_open = filt[4*NC]; // open load
    wire s_temp = filt[4*NC+1]; // over temperature
    wire s_ilim = filt[4*NC+2]; // boost peak current
    wire s_ovp = filt[4*NC+3]; // boost overvoltage
    wire s_zc = filt[4*NC+4]; // shunt polarity
    wire [2*NC-1:0] s_lvl = filt[SYN_W-1:4*NC+5]; // test comparator levels

    // monitoring is suppressed in diagnosis: drivers are off, test sources load the lines
    wire monitor = (o_state != `ST_DIAG); // [RQ6]
    wire [`FC_W-1:0] fault_hit; // fault causes seen this cycle
    assign fault_hit[`FC_SHORT_VS] = monitor & (|s_pos_vs | |s_ret_vs); // [RQ1]
    assign fault_hit[`FC_SHORT_GND] = monitor & (|s_pos_gnd | |s_ret_gnd); // [RQ1]
    assign fault_hit[`FC_OPEN_LOAD] = monitor & (o_state == `ST_OPER) & s_open; // [RQ5]
    assign fault_hit[`FC_OVER_TEMP] = monitor & s_temp; // [RQ5]
    wire fault_any = |fault_hit; // any shutdown cause

    // ===========================================================
    // operating state machine
    reg [1:0] next_state; // next operating state
    always @*
    begin
        next_state = o_state;
        case (o_state)
            `ST_IDLE:
            begin
                if (fault_any)
                    next_state = `ST_SHUT;
                else if (i_diag_enter)
                    next_state = `ST_DIAG; // [RQ18]
                else if (i_tx_start)
                    next_state = `ST_OPER;
            end
            `ST_OPER:
            begin
                if (fault_any)
                    next_state = `ST_SHUT; // [RQ1]
                else if (i_tx_stop)
                    next_state = `ST_IDLE;
            end
            `ST_SHUT:
            begin
                // transmissions ignored; only the reset-fault command leaves
                if (i_fault_clear && !fault_any)
                    next_state = `ST_IDLE; // [RQ7] [RQ19]
            end
            `ST_DIAG:
            begin
                if (i_diag_exit)
                    next_state = `ST_IDLE;
            end
            default:
                next_state = `ST_IDLE;
        endcase
    end

    // ===========================================================
    // state, fault cause, interrupt
    // a new fault in the clear cycle wins, so no event is lost
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_state <= `ST_IDLE;
            o_fault_cause <= `FAULT_RESET;
            o_irq <= 1'b0;
        end
        else
        begin
            o_state <= next_state;
            if (fault_any)
            begin
                o_fault_cause <= o_fault_cause | fault_hit; // [RQ3] [RQ20]
                o_irq <= 1'b1; // [RQ4]
            end
            else if (i_fault_clear)
            begin
                o_fault_cause <= `FAULT_RESET; // [RQ7] [RQ20]
                o_irq <= 1'b0;
            end
        end
    end

    // ===========================================================
    // driver and shunt outputs
    // inactive coils stay enabled as high-side outputs; only faults and diagnosis float all
    wire drv_ok = (next_state == `ST_IDLE) || (next_state == `ST_OPER);
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_drv_en <= {NC{1'b0}};
            o_shunt_conn <= 1'b0;
            o_diag_mode <= 1'b0;
            o_integ_hold_batt <= 1'b1;
        end
        else
        begin
            o_drv_en <= drv_ok ? {NC{1'b1}} : {NC{1'b0}}; // [RQ1] [RQ19]
            o_shunt_conn <= (next_state == `ST_OPER); // [RQ2]
            o_diag_mode <= (next_state == `ST_DIAG);
            o_integ_hold_batt <= (next_state != `ST_OPER); // [RQ16]
        end
    end

    // ===========================================================
    // current step register; any code below twenty accepted for either group
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_step_ref <= `STEP_RESET;
        else if (i_step_wr && (i_step_data < `NUM_STEPS))
            o_step_ref <= i_step_data; // [RQ11] [RQ15]
    end

    // ===========================================================
    // diagnosis test switches, latched per coil, and line readback
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_diag_sw <= {2*NC{1'b0}};
            o_line_status <= 2'h0;
        end
        else
        begin
            if (i_diag_wr && (o_state == `ST_DIAG) && (i_coil_sel < NC))
                o_diag_sw[2*i_coil_sel +: 2] <= i_diag_sw; // [RQ18]
            if (i_coil_sel < NC)
                o_line_status <= s_lvl[2*i_coil_sel +: 2]; // [RQ18]
            else
                o_line_status <= 2'h0;
        end
    end

    // ===========================================================
    // boost converter gating
    wire boost_tick; // start of a switching period
    wire boost_phase; // on-phase of a switching period
    wire boost_run = (o_state == `ST_OPER) && !fault_any; // [RQ8]
    lf_boost_divider #(
        .DIV(`BOOST_DIV),
        .W(`BOOST_DIV_W)
    ) u_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_run(boost_run),
        .o_tick(boost_tick),
        .o_phase(boost_phase)
    ); // [RQ10]

    reg ilim_cut; // switch held off for the rest of the period after peak limit
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_boost_en <= 1'b0;
            o_boost_gate <= 1'b0;
            ilim_cut <= 1'b0;
        end
        else
        begin
            o_boost_en <= boost_run && !s_ovp; // [RQ8] [RQ9]
            if (boost_tick)
                ilim_cut <= s_ilim;
            else if (s_ilim)
                ilim_cut <= 1'b1; // [RQ9]
            o_boost_gate <= boost_run && !s_ovp && boost_phase && !s_ilim && !ilim_cut; // [RQ9]
        end
    end

    // ===========================================================
    // zero crossing and peak sampling
    // peak of the positive half sits halfway between rising and falling crossings
    reg zc_prev; // previous shunt polarity
    reg [15:0] half_len; // measured length of the last positive half wave
    reg [15:0] pos_cnt; // cycles since rising crossing
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            zc_prev <= 1'b0;
            half_len <= 16'h0000;
            pos_cnt <= 16'h0000;
            o_peak_sample <= 1'b0;
        end
        else
        begin
            zc_prev <= s_zc;
            o_peak_sample <= 1'b0;
            if (s_zc && !zc_prev)
                pos_cnt <= 16'h0000; // [RQ17]
            else if (s_zc && (pos_cnt != 16'hffff))
                pos_cnt <= pos_cnt + 16'h0001;
            if (!s_zc && zc_prev)
                half_len <= pos_cnt; // [RQ17]
            if (s_zc && (o_state == `ST_OPER) && (half_len != 16'h0000)
                && (pos_cnt == {1'b0, half_len[15:1]}))
                o_peak_sample <= 1'b1; // [RQ17]
        end
    end
endmodule

// ---- lf_coil_checker.sv ----
// checker: port-level properties of the coil control block
`timescale 1ns/10ps
module lf_coil_checker #(
    parameter NC = 6,
    parameter SW = 5
) (
    input wire i_clk, // clock
    input wire i_rst_n, // async reset, active low
    input wire i_tx_start, // start pulse
    input wire i_step_wr, // step write strobe
    input wire [SW-1:0] i_step_data, // step code
    input wire i_over_temp, // overtemperature pin
    input wire i_boost_ovp, // overvoltage pin
    input wire i_fault_clear, // reset-fault pulse
    input wire [NC-1:0] o_drv_en, // driver enables
    input wire o_shunt_conn, // shunt connection
    input wire [3:0] o_fault_cause, // latched cause
    input wire o_irq, // interrupt level
    input wire [SW-1:0] o_step_ref, // step reference
    input wire o_boost_en, // boost enable
    input wire o_boost_gate, // boost gate
    input wire o_integ_hold_batt, // integrator hold
    input wire [1:0] o_state // operating state
);
    // ==========================================================
    // one domain: clock and reset given once
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    chk_shut_drivers_off: assert property (o_state == 2'h2 |-> o_drv_en == 0 && !o_shunt_conn)
        else $error("drivers or shunt active in shutdown");
    chk_shut_cause_irq: assert property (o_state == 2'h2 |-> o_irq && o_fault_cause != 4'h0)
        else $error("shutdown without cause or interrupt");
    // pin stable six cycles covers the synchroniser and filter delay
    chk_temp_shuts: assert property ((i_over_temp && o_state != 2'h3)[*6] |-> ##[0:2] o_state == 2'h2)
        else $error("overtemperature did not shut down");
    chk_irq_latched: assert property (o_irq && !i_fault_clear |=> o_irq)
        else $error("interrupt dropped without clear");
    chk_boost_in_tx: assert property (o_boost_en |-> $past(o_state) == 2'h1)
        else $error("boost enabled outside transmission");
    chk_ovp_stops: assert property (i_boost_ovp[*6] |-> !o_boost_en && !o_boost_gate)
        else $error("boost running under overvoltage");
    chk_gate_half: assert property ($rose(o_boost_gate) |-> ##32 !o_boost_gate)
        else $error("gate high time not half of 64");
    chk_step_taken: assert property (i_step_wr && i_step_data < 5'd20 |=> o_step_ref == $past(i_step_data))
        else $error("valid step not taken");
    chk_step_refused: assert property (i_step_wr && i_step_data >= 5'd20 |=> $stable(o_step_ref))
        else $error("invalid step changed reference");
    chk_idle_integ: assert property (o_integ_hold_batt == (o_state != 2'h1))
        else $error("integrator hold wrong for state");
    chk_shut_no_tx: assert property (o_state == 2'h2 && i_tx_start |=> o_state != 2'h1)
        else $error("transmission started in shutdown");
endmodule

bind lf_coil_ctrl lf_coil_checker #(.NC(NC), .SW(SW)) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx_start(i_tx_start), .i_step_wr(i_step_wr),
    .i_step_data(i_step_data), .i_over_temp(i_over_temp), .i_boost_ovp(i_boost_ovp),
    .i_fault_clear(i_fault_clear), .o_drv_en(o_drv_en), .o_shunt_conn(o_shunt_conn),
    .o_fault_cause(o_fault_cause), .o_irq(o_irq), .o_step_ref(o_step_ref),
    .o_boost_en(o_boost_en), .o_boost_gate(o_boost_gate),
    .o_integ_hold_batt(o_integ_hold_batt), .o_state(o_state)
);

// ---- mcu_model.sv ----
// controller model: issues command pulses on the control ports
`timescale 1ns/10ps
module mcu_model (
    input wire i_clk, // shared clock
    output reg [2:0] o_sel, // coil select
    output reg o_start, // start pulse
    output reg o_stop, // stop pulse
    output reg o_step_wr, // step write pulse
    output reg [4:0] o_step, // step code
    output reg o_d_enter, // diag enter pulse
    output reg o_d_exit, // diag exit pulse
    output reg [1:0] o_dsw, // test switch bits
    output reg o_d_wr, // test switch write pulse
    output reg o_clear // reset-fault pulse
);
    initial
    begin
        {o_sel, o_start, o_stop, o_step_wr, o_step, o_d_enter} = 12'h000;
        {o_d_exit, o_dsw, o_d_wr, o_clear} = 5'h00;
    end
    // ==========================================================
    // one command: set after a falling edge, pulse spans one rising edge
    task op(input [3:0] code, input [4:0] arg);
    begin
        @(negedge i_clk);
        case (code)
            4'h0: o_start = 1'b1;
            4'h1: o_stop = 1'b1;
            4'h2: {o_step_wr, o_step} = {1'b1, arg}; // caller picks group step
            4'h3: o_d_enter = 1'b1;
            4'h4: o_d_exit = 1'b1;
            4'h5: {o_d_wr, o_dsw} = {1'b1, arg[1:0]};
            4'h6: o_clear = 1'b1; // restores after shutdown
            default: o_sel = arg[2:0]; // selection is a level, no pulse
        endcase
        @(negedge i_clk);
        {o_start, o_stop, o_step_wr, o_d_enter, o_d_exit, o_d_wr, o_clear} = 7'h00;
    end
    endtask
endmodule

// ---- tb.sv ----
// testbench for the coil fault and current control block
`timescale 1ns/10ps
module tb;
    reg clk, rst_n, open_l, otemp, ilim, ovp, shs; // clock, reset and analog pins
    reg [5:0] psv, pgn, rsv, rgn; // line short pins
    reg [11:0] lvl; // line comparator pins
    wire [2:0] sel; // model command outputs
    wire [4:0] sdat;
    wire [1:0] dsw;
    wire tx_a, tx_b, swr, den, dex, dwr, fclr;
    wire [5:0] drv; // design outputs
    wire [3:0] cause;
    wire [4:0] sref;
    wire [11:0] dsw_o;
    wire [1:0] lstat, st;
    wire shunt, irq, ben, bgate, ihold, peak, dmode;
    integer n_mismatch, comparisons, n_peak, i, f, k, n;
    reg [31:0] seed, r;
    reg [4:0] c, e;
    mcu_model u_mcu (.i_clk(clk), .o_sel(sel), .o_start(tx_a), .o_stop(tx_b), .o_step_wr(swr),
        .o_step(sdat), .o_d_enter(den), .o_d_exit(dex), .o_dsw(dsw), .o_d_wr(dwr), .o_clear(fclr));
    lf_coil_ctrl u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_coil_sel(sel), .i_tx_start(tx_a),
        .i_tx_stop(tx_b), .i_step_wr(swr), .i_step_data(sdat), .i_diag_enter(den),
        .i_diag_exit(dex), .i_diag_sw(dsw), .i_diag_wr(dwr), .i_fault_clear(fclr),
        .i_pos_short_vs(psv), .i_pos_short_gnd(pgn), .i_ret_short_vs(rsv), .i_ret_short_gnd(rgn),
        .i_open_load(open_l), .i_over_temp(otemp), .i_boost_ilim(ilim), .i_boost_ovp(ovp),
        .i_shunt_sense_input(shs), .i_line_level(lvl), .o_drv_en(drv), .o_shunt_conn(shunt),
        .o_fault_cause(cause), .o_irq(irq), .o_step_ref(sref), .o_boost_en(ben),
        .o_boost_gate(bgate), .o_integ_hold_batt(ihold), .o_peak_sample(peak),
        .o_diag_mode(dmode), .o_diag_sw(dsw_o), .o_line_status(lstat), .o_state(st));
    // ==========================================================
    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // peak pulses counted on the edge where they stand
    always @(negedge clk)
        if (peak === 1'b1) n_peak = n_peak + 1;
    // xorshift source, fixed start so runs repeat
    function [31:0] xs;
    begin
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        xs = seed;
    end
    endfunction
    task summarize;
    begin
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    task chk(input [95:0] nm, input logic [15:0] seen, input logic [15:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("Error %0s expected %0h seen %0h", nm, exp, seen);
        end
    end
    endtask
    // bounded wait for a state; running out ends the run
    task wst(input [1:0] s);
        integer t;
    begin
        for (t = 0; st !== s && t < 20; t = t + 1)
            @(negedge clk);
        chk("state", st, s);
        if (st !== s) summarize;
    end
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        {rst_n, open_l, otemp, ilim, ovp, shs, psv, pgn, rsv, rgn, lvl} = 42'h0;
        {n_mismatch, comparisons, n_peak, e, seed} = {96'h0, 5'h00, 32'h00014eac};
        repeat (4) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("drv_en", drv, 6'h3f);
        chk("cause", {irq, cause, sref}, 10'h000);
        // codes 0 to 23, the refused ones 20 to 23 too, then random codes
        for (i = 0; i < 32; i = i + 1)
        begin
            r = xs();
            c = (i < 24) ? i[4:0] : r[4:0];
            u_mcu.op(4'h2, c);
            if (c < 5'd20) e = c;
            chk("step_ref", sref, e);
        end
        u_mcu.op(4'h0, 5'h00);
        wst(2'h1);
        chk("op_out", {shunt, ihold}, 2'b10);
        @(negedge clk) chk("boost_en", ben, 1'b1);
        n = 0;
        repeat (64) @(negedge clk) n = n + bgate;
        chk("gate_high", n, 32);
        // six positive halves of 20 cycles; the first has no measured length yet
        repeat (12)
        begin
            repeat (20) @(negedge clk);
            shs = ~shs;
        end
        chk("peaks", n_peak, 5);
        ilim = 1'b1;
        repeat (8) @(negedge clk);
        chk("gate_ilim", bgate, 1'b0);
        {ilim, ovp} = 2'b01;
        repeat (8) @(negedge clk);
        chk("boost_ovp", ben, 1'b0);
        ovp = 1'b0;
        u_mcu.op(4'h1, 5'h00);
        wst(2'h0);
        @(negedge clk) chk("idle_out", {ben, ihold}, 2'b01);
        // faults: line shorts in idle, open load in transmission, temperature
        for (f = 0; f < 6; f = f + 1)
        begin
            r = xs();
            k = r % 6;
            if (f == 4) u_mcu.op(4'h0, 5'h00);
            case (f)
                0: psv[k] = 1'b1;
                1: pgn[k] = 1'b1;
                2: rsv[k] = 1'b1;
                3: rgn[k] = 1'b1;
                4: open_l = 1'b1;
                default: otemp = 1'b1;
            endcase
            wst(2'h2);
            chk("drv_off", {drv, shunt}, 7'h00);
            chk("irq", irq, 1'b1);
            chk("cause", cause, (f == 4) ? 4'h4 : (f == 5) ? 4'h8 : (f[0] ? 4'h2 : 4'h1));
            u_mcu.op(4'h0, 5'h00);
            chk("shut_tx", st, 2'h2);
            {psv, pgn, rsv, rgn, open_l, otemp} = 26'h0;
            repeat (10) @(negedge clk);
            chk("held", {irq, st}, 3'h6);
            u_mcu.op(4'h6, 5'h00);
            wst(2'h0);
            @(negedge clk) chk("cleared", {irq, cause}, 5'h00);
            u_mcu.op(4'h0, 5'h00);
            wst(2'h1);
            u_mcu.op(4'h1, 5'h00);
            wst(2'h0);
        end
        // test structures: latch switches per coil, read line levels back
        u_mcu.op(4'h3, 5'h00);
        wst(2'h3);
        chk("diag_mode", dmode, 1'b1);
        for (k = 0; k < 6; k = k + 1)
        begin
            r = xs();
            u_mcu.op(4'h7, k[4:0]);
            u_mcu.op(4'h5, {3'h0, r[1:0]});
            chk("diag_sw", dsw_o[2*k+:2], r[1:0]);
            lvl = r[13:2];
            repeat (6) @(negedge clk);
            chk("line", lstat, lvl[2*k+:2]);
        end
        u_mcu.op(4'h4, 5'h00);
        wst(2'h0);
        // chip reset also leaves shutdown and drops the latched cause
        otemp = 1'b1;
        wst(2'h2);
        @(negedge clk) {rst_n, otemp} = 2'b00;
        @(negedge clk) rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("rst_shut", {irq, cause, st, drv}, 13'h003f);
        summarize;
    end
endmodule
